// >>> hw/timer8_pkg.sv
package timer8_pkg;

    // Register indices on the plain register port
    localparam logic [2:0] CTRL_ADDR    = 3'h0;
    localparam logic [2:0] COUNT_ADDR   = 3'h1;
    localparam logic [2:0] COMPARE_ADDR = 3'h2;
    localparam logic [2:0] FLAGS_ADDR   = 3'h3;
    localparam logic [2:0] IRQ_EN_ADDR  = 3'h4;

    // Field positions in the flag and enable registers
    localparam int OVF_BIT = 0;
    localparam int CMP_BIT = 1;

    // Reset values
    localparam logic [7:0] CTRL_RST  = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] CMP_RST   = 8'h00;
    localparam logic [1:0] FLAG_RST  = 2'h0;
    localparam logic [1:0] IEN_RST   = 2'h0;

    // Counter extremes
    localparam logic [7:0] BOTTOM_VAL = 8'h00;
    localparam logic [7:0] MAX_VAL    = 8'hFF;

    // Waveform modes, {waveform_mode_hi, waveform_mode_lo}
    localparam logic [1:0] WM_NORMAL    = 2'h0;
    localparam logic [1:0] WM_PHASE_PWM = 2'h1;
    localparam logic [1:0] WM_CLEAR     = 2'h2;
    localparam logic [1:0] WM_FAST_PWM  = 2'h3;

    // Compare output modes
    localparam logic [1:0] COM_OFF    = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;

    // Clock source select codes
    localparam logic [2:0] CS_STOP     = 3'h0;
    localparam logic [2:0] CS_SYS      = 3'h1;
    localparam logic [2:0] CS_DIV8     = 3'h2;
    localparam logic [2:0] CS_DIV64    = 3'h3;
    localparam logic [2:0] CS_DIV256   = 3'h4;
    localparam logic [2:0] CS_DIV1024  = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;

    // Layout of the control register
    typedef struct packed {
        logic       force_compare_strobe;
        logic       waveform_mode_lo;
        logic [1:0] compare_output_mode;
        logic       waveform_mode_hi;
        logic [2:0] clock_source_select;
    } timer_control_t;

    // Pin override pair
    typedef struct packed {
        logic level;
        logic enable;
    } pin_drive_t;

endpackage : timer8_pkg

// >>> hw/timer8_output_compare.sv
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - Clock select zero stops counting; counter stays readable and writable.
// - Each tick clears, increments or decrements the counter per mode.
// - A CPU counter write beats any count or clear in that cycle.
// - Bottom flags counter zero, top flags end of the count sequence.
// - Waveform mode sets count sequence and when the overflow flag sets.
// - Eight-bit comparator flags a match whenever counter equals active compare.
// - Match sets the compare flag on the next tick, not earlier.
// - Compare request only when flag, enable and global enable are all set.
// - Flag clears on service, or by writing one; writing zero keeps it.
// - PWM modes reach a buffer; other modes reach active compare directly.
// - Buffered compare loads into active only at top (phase PWM: at top while counting up).
// - Force strobe in non-PWM modes acts like a match, no flag, no clear.
// - Counter write blocks matches at the next tick, even when stopped.
// - Output state holds its value across waveform mode changes.
// - Output mode bits are unbuffered and act at once.
// - Output mode picks next match action and whether the pin is overridden.
// - Reset clears the output state to zero.
// - Nonzero output mode puts output state on the pin; direction from port.
// - Override ignores waveform mode; pin shows it only when direction is output.
// - Bottom is 00, max FF, top FF or compare per mode.
// - Normal mode counts up, wraps FF to 00, overflow set on reaching zero.
// - Clear-on-match mode clears the counter at a compare match.
// - Output mode zero does nothing to the output state at a match.
module timer8_output_compare
    import timer8_pkg::*;
(
    input  wire  logic       CLK,
    input  wire  logic       RSTN,
    input  wire  logic [2:0] ADDR,
    input  wire  logic [7:0] WDATA,
    input  wire  logic       WR,
    input  wire  logic       RD,
    output logic       [7:0] RDATA,
    input  wire  logic [3:0] PRESCALE_TICKS,
    input  wire  logic       EXT_CLK_PIN,
    input  wire  logic       GLOBAL_IRQ_EN,
    input  wire  logic       COMPARE_IRQ_ACK,
    input  wire  logic       OVERFLOW_IRQ_ACK,
    output logic             COMPARE_IRQ,
    output logic             OVERFLOW_IRQ,
    input  wire  logic       PORT_VALUE,
    input  wire  logic       OUTPUT_PIN_DIRECTION,
    output logic             PIN_OUT,
    output logic             PIN_OE
);

    logic           rst_s1_ff;
    logic           rst_n;
    logic           ext_s1_ff;
    logic           ext_s2_ff;
    logic           ext_s3_ff;
    timer_control_t ctrl_ff;
    logic [7:0]     counter_value_ff;
    logic [7:0]     nxt_counter_value;
    logic [7:0]     compare_value_ff;
    logic [7:0]     compare_buf_ff;
    logic           count_down_ff;
    logic           nxt_count_down;
    logic           compare_flag_ff;
    logic           overflow_flag_ff;
    logic [1:0]     irq_en_ff;
    logic           block_ff;
    logic           compare_output_state_ff;
    logic [7:0]     rdata_ff;
    logic           timer_tick;
    logic [1:0]     waveform_mode;
    logic           pwm_mode;
    logic           match;
    logic           eff_match;
    logic           at_top;
    logic           at_bottom;
    logic           ovf_event;
    logic           count_wr;
    logic           ctrl_wr;
    logic           cmp_wr;
    logic           flags_wr;
    pin_drive_t     pin_drv;

    function automatic logic is_access(input logic strobe, input logic [2:0] a,
                                       input logic [2:0] target);
        is_access = strobe && (a == target);
    endfunction : is_access

    // Reset release
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_s1_ff <= 1'b0;
            rst_n     <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_n     <= rst_s1_ff;
        end
    end

    // External clock pin synchroniser and edge history
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ext_s1_ff <= 1'b0;
            ext_s2_ff <= 1'b0;
            ext_s3_ff <= 1'b0;
        end else begin
            ext_s1_ff <= EXT_CLK_PIN;
            ext_s2_ff <= ext_s1_ff;
            ext_s3_ff <= ext_s2_ff;
        end
    end

    // Tick select
    always_comb begin
        case (ctrl_ff.clock_source_select)
            CS_STOP:     timer_tick = 1'b0;
            CS_SYS:      timer_tick = 1'b1;
            CS_DIV8:     timer_tick = PRESCALE_TICKS[0];
            CS_DIV64:    timer_tick = PRESCALE_TICKS[1];
            CS_DIV256:   timer_tick = PRESCALE_TICKS[2];
            CS_DIV1024:  timer_tick = PRESCALE_TICKS[3];
            CS_EXT_FALL: timer_tick = ext_s3_ff && !ext_s2_ff;
            CS_EXT_RISE: timer_tick = !ext_s3_ff && ext_s2_ff;
            default:     timer_tick = 1'b0;
        endcase
    end

    assign count_wr      = is_access(WR, ADDR, COUNT_ADDR);
    assign ctrl_wr       = is_access(WR, ADDR, CTRL_ADDR);
    assign cmp_wr        = is_access(WR, ADDR, COMPARE_ADDR);
    assign flags_wr      = is_access(WR, ADDR, FLAGS_ADDR);
    assign waveform_mode = {ctrl_ff.waveform_mode_hi, ctrl_ff.waveform_mode_lo};
    assign pwm_mode      = waveform_mode[0];
    assign match         = (counter_value_ff == compare_value_ff);
    assign eff_match     = timer_tick && match && !block_ff;
    assign at_bottom     = (counter_value_ff == BOTTOM_VAL);
    assign at_top        = (waveform_mode == WM_CLEAR) ? match
                                                       : (counter_value_ff == MAX_VAL);

    // Count sequence per waveform mode
    always_comb begin
        nxt_counter_value = counter_value_ff;
        nxt_count_down    = count_down_ff;
        ovf_event         = 1'b0;
        if (timer_tick) begin
            case (waveform_mode)
                WM_PHASE_PWM: begin
                    if (!count_down_ff && at_top) begin
                        nxt_count_down    = 1'b1;
                        nxt_counter_value = counter_value_ff - 8'h01;
                    end else if (count_down_ff && at_bottom) begin
                        nxt_count_down    = 1'b0;
                        nxt_counter_value = counter_value_ff + 8'h01;
                        ovf_event         = 1'b1;
                    end else if (count_down_ff) begin
                        nxt_counter_value = counter_value_ff - 8'h01;
                    end else begin
                        nxt_counter_value = counter_value_ff + 8'h01;
                    end
                end
                WM_CLEAR: begin
                    nxt_count_down = 1'b0;
                    if (eff_match) begin
                        nxt_counter_value = BOTTOM_VAL;
                    end else begin
                        nxt_counter_value = counter_value_ff + 8'h01;
                    end
                    ovf_event = (counter_value_ff == MAX_VAL);
                end
                default: begin
                    nxt_count_down    = 1'b0;
                    nxt_counter_value = counter_value_ff + 8'h01;
                    ovf_event         = (counter_value_ff == MAX_VAL);
                end
            endcase
        end
        if (count_wr) begin
            nxt_counter_value = WDATA;
        end
    end

    // Counter and direction
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            counter_value_ff <= COUNT_RST;
            count_down_ff    <= 1'b0;
        end else begin
            counter_value_ff <= nxt_counter_value;
            count_down_ff    <= nxt_count_down;
        end
    end

    // Match blocking after a counter write
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            block_ff <= 1'b0;
        end else if (count_wr) begin
            block_ff <= 1'b1;
        end else if (timer_tick) begin
            block_ff <= 1'b0;
        end
    end

    // Control and enable registers
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff   <= CTRL_RST;
            irq_en_ff <= IEN_RST;
        end else begin
            ctrl_ff.force_compare_strobe <= 1'b0;
            if (ctrl_wr) begin
                ctrl_ff <= timer_control_t'(WDATA);
            end
            if (is_access(WR, ADDR, IRQ_EN_ADDR)) begin
                irq_en_ff <= WDATA[1:0];
            end
        end
    end

    // Compare buffer and active compare
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            compare_buf_ff   <= CMP_RST;
            compare_value_ff <= CMP_RST;
        end else begin
            if (cmp_wr) begin
                compare_buf_ff <= WDATA;
            end
            if (!pwm_mode) begin
                if (cmp_wr) begin
                    compare_value_ff <= WDATA;
                end
            end else if (timer_tick) begin
                if ((waveform_mode == WM_FAST_PWM && at_top) ||
                    (waveform_mode == WM_PHASE_PWM && !count_down_ff && at_top)) begin
                    compare_value_ff <= compare_buf_ff;
                end
            end
        end
    end

    // Flags: hardware set wins over clear
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            compare_flag_ff  <= FLAG_RST[CMP_BIT];
            overflow_flag_ff <= FLAG_RST[OVF_BIT];
        end else begin
            if (eff_match) begin
                compare_flag_ff <= 1'b1;
            end else if (COMPARE_IRQ_ACK || (flags_wr && WDATA[CMP_BIT])) begin
                compare_flag_ff <= 1'b0;
            end
            if (ovf_event) begin
                overflow_flag_ff <= 1'b1;
            end else if (OVERFLOW_IRQ_ACK || (flags_wr && WDATA[OVF_BIT])) begin
                overflow_flag_ff <= 1'b0;
            end
        end
    end

    assign COMPARE_IRQ  = compare_flag_ff && irq_en_ff[CMP_BIT] && GLOBAL_IRQ_EN;
    assign OVERFLOW_IRQ = overflow_flag_ff && irq_en_ff[OVF_BIT] && GLOBAL_IRQ_EN;

    // Output state register
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            compare_output_state_ff <= 1'b0;
        end else if (!pwm_mode && ctrl_wr && WDATA[7]) begin
            case (ctrl_ff.compare_output_mode)
                COM_TOGGLE: compare_output_state_ff <= !compare_output_state_ff;
                COM_CLEAR:  compare_output_state_ff <= 1'b0;
                COM_SET:    compare_output_state_ff <= 1'b1;
                default:    compare_output_state_ff <= compare_output_state_ff;
            endcase
        end else if (timer_tick) begin
            case (ctrl_ff.compare_output_mode)
                COM_TOGGLE: if (eff_match) compare_output_state_ff <= !compare_output_state_ff;
                COM_CLEAR, COM_SET: begin
                    if (eff_match) begin
                        compare_output_state_ff <= (ctrl_ff.compare_output_mode == COM_SET)
                                                   ^ (waveform_mode == WM_PHASE_PWM
                                                      && count_down_ff);
                    end else if (waveform_mode == WM_FAST_PWM && at_top) begin
                        compare_output_state_ff <= (ctrl_ff.compare_output_mode == COM_CLEAR);
                    end
                end
                default: compare_output_state_ff <= compare_output_state_ff;
            endcase
        end
    end

    // Pin override
    assign pin_drv        = '{level:  (ctrl_ff.compare_output_mode != COM_OFF)
                                      ? compare_output_state_ff : PORT_VALUE,
                              enable: OUTPUT_PIN_DIRECTION};
    assign PIN_OUT        = pin_drv.level;
    assign PIN_OE         = pin_drv.enable;

    // Read data, one cycle after the read strobe
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 8'h00;
        end else if (RD) begin
            case (ADDR)
                CTRL_ADDR:    rdata_ff <= {1'b0, ctrl_ff[6:0]};
                COUNT_ADDR:   rdata_ff <= counter_value_ff;
                COMPARE_ADDR: rdata_ff <= pwm_mode ? compare_buf_ff : compare_value_ff;
                FLAGS_ADDR:   rdata_ff <= {6'h00, compare_flag_ff, overflow_flag_ff};
                IRQ_EN_ADDR:  rdata_ff <= {6'h00, irq_en_ff};
                default:      rdata_ff <= 8'h00;
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end
    assign RDATA = rdata_ff;

    sequence seq_count_write;
        count_wr;
    endsequence

    sequence seq_live_match;
        timer_tick && match && !block_ff && !count_wr;
    endsequence

    AST_STOPPED_HOLDS: assert property (@(posedge CLK) disable iff (!rst_n)
        (ctrl_ff.clock_source_select == CS_STOP && !count_wr && !ctrl_wr)
        |=> $stable(counter_value_ff))
        else $error("Counter moved while stopped");

    AST_WRITE_WINS: assert property (@(posedge CLK) disable iff (!rst_n)
        seq_count_write |=> (counter_value_ff == $past(WDATA)))
        else $error("Counter write lost");

    AST_FLAG_ON_TICK: assert property (@(posedge CLK) disable iff (!rst_n)
        $rose(compare_flag_ff) |-> $past(timer_tick && match))
        else $error("Compare flag set without tick match");

    AST_FLAG_SETS: assert property (@(posedge CLK) disable iff (!rst_n)
        seq_live_match |=> compare_flag_ff)
        else $error("Compare flag missed a match");

    AST_IRQ_GATE: assert property (@(posedge CLK) disable iff (!rst_n)
        COMPARE_IRQ |-> (compare_flag_ff && irq_en_ff[CMP_BIT] && GLOBAL_IRQ_EN))
        else $error("Compare request without enables");

    AST_BLOCKED: assert property (@(posedge CLK) disable iff (!rst_n)
        seq_count_write ##1 (!timer_tick && !count_wr)[*3] ##1 timer_tick
        |=> !$rose(compare_flag_ff))
        else $error("Match not blocked after counter write");

    AST_CLEAR_ON_MATCH: assert property (@(posedge CLK) disable iff (!rst_n)
        (waveform_mode == WM_CLEAR) and seq_live_match |=> (counter_value_ff == BOTTOM_VAL))
        else $error("Clear-on-match failed");

    AST_NORMAL_WRAP: assert property (@(posedge CLK) disable iff (!rst_n)
        (waveform_mode == WM_NORMAL && timer_tick && counter_value_ff == MAX_VAL && !count_wr)
        |=> (counter_value_ff == BOTTOM_VAL && overflow_flag_ff))
        else $error("Normal wrap or overflow wrong");

    AST_FORCE_NO_FLAG: assert property (@(posedge CLK) disable iff (!rst_n)
        (ctrl_wr && WDATA[7] && !pwm_mode && ctrl_ff.compare_output_mode == COM_SET && !timer_tick)
        |=> (compare_output_state_ff && !$rose(compare_flag_ff)))
        else $error("Force strobe misbehaved");

    AST_PIN_OVERRIDE: assert property (@(posedge CLK) disable iff (!rst_n)
        (ctrl_ff.compare_output_mode != COM_OFF) |-> (PIN_OUT == compare_output_state_ff))
        else $error("Pin not overridden");

endmodule : timer8_output_compare

// >>> bench/cpu_port_model.sv
`timescale 1ns/1ps
module cpu_port_model (
    input  wire logic clk,
    input  wire logic service,
    input  wire logic compare_irq,
    input  wire logic overflow_irq,
    output logic      compare_ack,
    output logic      overflow_ack
);
    // Interrupt service: one-cycle acknowledge per taken request
    initial begin
        compare_ack  = 1'b0;
        overflow_ack = 1'b0;
    end
    always @(posedge clk) begin
        compare_ack  <= service & compare_irq & ~compare_ack;
        overflow_ack <= service & overflow_irq & ~overflow_ack & ~compare_irq;
    end
endmodule : cpu_port_model

// >>> bench/tb.sv
`timescale 1ns/1ps
module tb;
    import timer8_pkg::*;
    logic       clk, rstn, wr, rd, ext, glob, port, dir, service;
    logic       cmp_irq, ovf_irq, cmp_ack, ovf_ack, pin_out, pin_oe;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, rv, sv, cv;
    logic [3:0] ticks;
    logic [1:0] com_tab [3] = '{COM_SET, COM_CLEAR, COM_TOGGLE};
    logic       oc_tab  [3] = '{1'b1, 1'b0, 1'b1};
    int         miscompares, n_checks, cyc, n;

    timer8_output_compare timer8_output_compare_inst (
        .CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .PRESCALE_TICKS(ticks), .EXT_CLK_PIN(ext), .GLOBAL_IRQ_EN(glob),
        .COMPARE_IRQ_ACK(cmp_ack), .OVERFLOW_IRQ_ACK(ovf_ack), .COMPARE_IRQ(cmp_irq),
        .OVERFLOW_IRQ(ovf_irq), .PORT_VALUE(port), .OUTPUT_PIN_DIRECTION(dir),
        .PIN_OUT(pin_out), .PIN_OE(pin_oe));
    cpu_port_model cpu_port_model_inst (
        .clk(clk), .service(service), .compare_irq(cmp_irq), .overflow_irq(ovf_irq),
        .compare_ack(cmp_ack), .overflow_ack(ovf_ack));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [7:0] ctl(input logic [2:0] cs, input logic [1:0] wm,
                                       input logic [1:0] com, input logic f);
        return {f, wm[0], com, wm[1], cs};
    endfunction : ctl

    task automatic finish_test;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk8

    task automatic chk1(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask : chk1

    task automatic bus_wr(input logic [2:0] a, input logic [7:0] d, input logic tk = 1'b0);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        ticks <= {3'h0, tk};
        @(posedge clk);
        wr    <= 1'b0;
        ticks <= 4'h0;
        #1;
    endtask : bus_wr

    task automatic bus_rd(input logic [2:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        rv = rdata;
    endtask : bus_rd

    task automatic rchk(input logic [2:0] a, input logic [7:0] e, input string nm);
        bus_rd(a);
        chk8(nm, e, rv);
    endtask : rchk

    task automatic fchk(input int b, input logic e);
        bus_rd(FLAGS_ADDR);
        chk1("flag bit", e, rv[b]);
    endtask : fchk

    task automatic tick(input logic [3:0] m, input int k);
        repeat (k) begin
            @(posedge clk);
            ticks <= m;
            @(posedge clk);
            ticks <= 4'h0;
        end
        #1;
    endtask : tick

    task automatic drive(input logic g, input logic p, input logic d, input logic s);
        @(posedge clk);
        glob    <= g;
        port    <= p;
        dir     <= d;
        service <= s;
        @(posedge clk);
        #1;
    endtask : drive

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares++;
            finish_test();
        end
    end

    initial begin
        {rstn, wr, rd, ext, glob, service, addr, wdata, ticks} = '0;
        {port, dir} = 2'b11;
        {miscompares, n_checks, cyc} = '0;
        rv = 8'($urandom(32'hC93334AE));
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk1("pin_out", 1'b1, pin_out);
        chk1("pin_oe", 1'b1, pin_oe);
        for (int a = 0; a < 6; a++) rchk(3'(a), 8'h00, "reset value");
        bus_wr(CTRL_ADDR, ctl(CS_STOP, WM_NORMAL, COM_TOGGLE, 1'b0));
        chk1("pin_out", 1'b0, pin_out);
        bus_wr(CTRL_ADDR, ctl(CS_STOP, WM_NORMAL, COM_OFF, 1'b0));
        for (int i = 0; i < 4; i++) begin
            sv = 8'($urandom);
            bus_wr(COUNT_ADDR, sv);
            tick(4'hF, 2);
            rchk(COUNT_ADDR, sv, "stopped count");
        end
        for (int cs = 2; cs < 6; cs++) begin
            bus_wr(CTRL_ADDR, ctl(3'(cs), WM_NORMAL, COM_OFF, 1'b0));
            bus_wr(COUNT_ADDR, 8'h00);
            tick(~(4'h1 << (cs - 2)), 1);
            tick(4'h1 << (cs - 2), 2);
            rchk(COUNT_ADDR, 8'h02, "prescaled count");
        end
        for (int cs = 6; cs < 8; cs++) begin
            bus_wr(CTRL_ADDR, ctl(3'(cs), WM_NORMAL, COM_OFF, 1'b0));
            bus_wr(COUNT_ADDR, 8'h00);
            repeat (2) begin
                @(posedge clk);
                ext <= ~ext;
                repeat (6) @(posedge clk);
            end
            rchk(COUNT_ADDR, 8'h01, "pin edge count");
        end
        bus_wr(COUNT_ADDR, 8'h00);
        bus_wr(CTRL_ADDR, ctl(CS_SYS, WM_NORMAL, COM_OFF, 1'b0));
        bus_wr(CTRL_ADDR, ctl(CS_DIV8, WM_NORMAL, COM_OFF, 1'b0));
        rchk(COUNT_ADDR, 8'h02, "system clock count");
        for (int i = 0; i < 8; i++) begin
            sv = (i == 0) ? 8'hFE : 8'($urandom);
            n  = (i == 0) ? 2 : 1 + ($urandom % 4);
            bus_wr(COUNT_ADDR, sv);
            bus_wr(FLAGS_ADDR, 8'h03);
            tick(4'h1, n);
            rchk(COUNT_ADDR, sv + 8'(n), "count");
            fchk(OVF_BIT, (int'(sv) + n) > 255);
        end
        bus_wr(COUNT_ADDR, 8'h40, 1'b1);
        rchk(COUNT_ADDR, 8'h40, "write beats tick");
        cv = 8'(10 + $urandom % 200);
        bus_wr(COMPARE_ADDR, cv);
        bus_wr(COUNT_ADDR, cv - 8'h01);
        bus_wr(FLAGS_ADDR, 8'h03);
        tick(4'h1, 1);
        fchk(CMP_BIT, 1'b0);
        tick(4'h1, 1);
        fchk(CMP_BIT, 1'b1);
        bus_wr(FLAGS_ADDR, 8'h00);
        fchk(CMP_BIT, 1'b1);
        bus_wr(IRQ_EN_ADDR, 8'h02);
        drive(1'b0, 1'b1, 1'b1, 1'b0);
        chk1("compare_irq", 1'b0, cmp_irq);
        drive(1'b1, 1'b1, 1'b1, 1'b0);
        chk1("compare_irq", 1'b1, cmp_irq);
        bus_wr(IRQ_EN_ADDR, 8'h00);
        chk1("compare_irq", 1'b0, cmp_irq);
        bus_wr(IRQ_EN_ADDR, 8'h02);
        drive(1'b1, 1'b1, 1'b1, 1'b1);
        repeat (3) @(posedge clk);
        fchk(CMP_BIT, 1'b0);
        drive(1'b0, 1'b0, 1'b1, 1'b0);
        bus_wr(CTRL_ADDR, ctl(CS_STOP, WM_NORMAL, COM_OFF, 1'b0));
        bus_wr(COUNT_ADDR, cv);
        bus_wr(CTRL_ADDR, ctl(CS_DIV8, WM_NORMAL, COM_OFF, 1'b0));
        tick(4'h1, 2);
        fchk(CMP_BIT, 1'b0);
        bus_wr(CTRL_ADDR, ctl(CS_DIV8, WM_CLEAR, COM_OFF, 1'b0));
        bus_wr(COMPARE_ADDR, 8'h03);
        bus_wr(COUNT_ADDR, 8'h00);
        tick(4'h1, 5);
        rchk(COUNT_ADDR, 8'h01, "clear on match count");
        bus_wr(CTRL_ADDR, ctl(CS_DIV8, WM_NORMAL, COM_OFF, 1'b0));
        bus_wr(COMPARE_ADDR, 8'h10);
        bus_wr(CTRL_ADDR, ctl(CS_DIV8, WM_FAST_PWM, COM_OFF, 1'b0));
        bus_wr(COMPARE_ADDR, 8'h20);
        rchk(COMPARE_ADDR, 8'h20, "compare buffer");
        bus_wr(COUNT_ADDR, 8'h0F);
        bus_wr(FLAGS_ADDR, 8'h03);
        tick(4'h1, 2);
        fchk(CMP_BIT, 1'b1);
        bus_wr(COUNT_ADDR, 8'hFE);
        tick(4'h1, 3);
        bus_wr(IRQ_EN_ADDR, 8'h01);
        drive(1'b1, 1'b0, 1'b1, 1'b0);
        chk1("overflow_irq", 1'b1, ovf_irq);
        bus_wr(COUNT_ADDR, 8'h1F);
        bus_wr(FLAGS_ADDR, 8'h03);
        tick(4'h1, 2);
        fchk(CMP_BIT, 1'b1);
        bus_wr(CTRL_ADDR, ctl(CS_STOP, WM_NORMAL, COM_OFF, 1'b0));
        bus_wr(FLAGS_ADDR, 8'h03);
        foreach (com_tab[i]) begin
            bus_wr(CTRL_ADDR, ctl(CS_STOP, WM_NORMAL, com_tab[i], 1'b0));
            bus_wr(CTRL_ADDR, ctl(CS_STOP, WM_NORMAL, com_tab[i], 1'b1));
            chk1("forced pin_out", oc_tab[i], pin_out);
        end
        fchk(CMP_BIT, 1'b0);
        bus_wr(CTRL_ADDR, ctl(CS_STOP, WM_FAST_PWM, COM_TOGGLE, 1'b0));
        chk1("pin_out after mode change", 1'b1, pin_out);
        bus_wr(CTRL_ADDR, ctl(CS_STOP, WM_FAST_PWM, COM_TOGGLE, 1'b1));
        chk1("pin_out force in PWM", 1'b1, pin_out);
        bus_wr(CTRL_ADDR, ctl(CS_STOP, WM_NORMAL, COM_OFF, 1'b0));
        chk1("pin_out port value", 1'b0, pin_out);
        drive(1'b0, 1'b0, 1'b0, 1'b0);
        chk1("pin_oe", 1'b0, pin_oe);
        drive(1'b0, 1'b0, 1'b1, 1'b0);
        bus_wr(CTRL_ADDR, ctl(CS_DIV8, WM_NORMAL, COM_OFF, 1'b0));
        bus_wr(COMPARE_ADDR, 8'h05);
        bus_wr(COUNT_ADDR, 8'h04);
        tick(4'h1, 3);
        bus_wr(CTRL_ADDR, ctl(CS_STOP, WM_NORMAL, COM_TOGGLE, 1'b0));
        chk1("pin_out idle match", 1'b1, pin_out);
        bus_wr(CTRL_ADDR, ctl(CS_DIV8, WM_NORMAL, COM_TOGGLE, 1'b0));
        bus_wr(COUNT_ADDR, 8'h04);
        tick(4'h1, 3);
        chk1("pin_out toggled", 1'b0, pin_out);
        finish_test();
    end
endmodule : tb
